/* sdi_output_path_config.sv */
`timescale 1ns/1ps
`default_nettype none
module sdi_output_path_config #(
    parameter int SWING_W = 10,
    parameter int PRE_W = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    // pins, asynchronous to core_clk
    input wire logic direction_mode_select,
    input wire logic [1:0] out_function_strap,
    input wire logic [1:0] coax_amplitude_select,
    input wire logic [1:0] host_link_strap,
    input wire logic host_output_enable_pin,
    // reclocker rate report, same clock
    input wire logic [2:0] detected_rate,
    input wire logic rate_valid,
    // control bits
    input wire logic bypass_override,
    input wire logic bypass_cable_eq_value,
    input wire logic bypass_reclocker_value,
    input wire logic coax_amp_override,
    input wire logic [1:0] coax_amp_value,
    input wire logic coax_nominal_override,
    input wire logic [SWING_W-1:0] coax_nominal_value,
    input wire logic preemph_auto_disable,
    input wire logic bidir_preemph_manual,
    input wire logic secondary_preemph_manual,
    input wire logic [PRE_W-1:0] preemph_amount_value,
    input wire logic [2:0] edge_rate_value,
    input wire logic invert_bidir,
    input wire logic invert_secondary,
    input wire logic invert_host,
    input wire logic host_link_override,
    input wire logic [1:0] host_link_value,
    input wire logic host_swing_override,
    input wire logic [9:0] host_swing_value,
    input wire logic host_deemph_override,
    input wire logic [5:0] host_deemph_value,
    // resolved configuration
    output logic drive_mode,
    output logic cable_eq_enable,
    output logic host_link_strap_level_enable,
    output logic reclocker_bypass,
    output logic fixed_boost_mode,
    output logic [1:0] host_link_strap_level,
    output logic bidir_drive_enable,
    output logic secondary_drive_enable,
    output logic [SWING_W:0] coax_swing_mv,
    output logic bidir_preemph_enable,
    output logic secondary_preemph_enable,
    output logic [PRE_W-1:0] preemph_amount,
    output logic [2:0] coax_edge_rate,
    output logic bidir_invert,
    output logic secondary_invert,
    output logic host_invert,
    output logic host_loopback_select,
    output logic host_output_enable,
    output logic [9:0] host_swing_mv,
    output logic [5:0] host_deemph_tenth_db
);
    if (SWING_W < 10) begin : g_chk
        $error("SWING_W must hold the nominal coax swing");
    end
    if (PRE_W < 1) begin : g_chk_pre
        $error("PRE_W must be at least one bit");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic dir_meta, dir_sync, oe_meta, oe_sync;
    logic [1:0] ofs_meta, ofs_sync, amp_meta, amp_sync;
    logic [1:0] hls_meta, hls_sync;

    always_ff @(posedge core_clk) begin
        dir_meta <= direction_mode_select;
        dir_sync <= dir_meta;
        oe_meta <= host_output_enable_pin;
        oe_sync <= oe_meta;
        ofs_meta <= out_function_strap;
        ofs_sync <= ofs_meta;
        amp_meta <= coax_amplitude_select;
        amp_sync <= amp_meta;
        hls_meta <= host_link_strap;
        hls_sync <= hls_meta;
    end

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [1:0] pick(input logic ovr,
                                        input logic [1:0] reg_val,
                                        input logic [1:0] strap);
        pick = ovr ? reg_val : strap;
    endfunction

    function automatic logic [SWING_W:0] scale(input logic [SWING_W:0] n,
                                               input logic [1:0] lvl);
        logic [SWING_W:0] f20;
        logic [SWING_W:0] f10;
        f20 = n / (SWING_W+1)'(20);
        f10 = n / (SWING_W+1)'(10);
        unique case (lvl)
            secondary_coax_output_cfg_pkg::LVL_HIGH: scale = n + f20;
            secondary_coax_output_cfg_pkg::LVL_RES: scale = n + f10;
            secondary_coax_output_cfg_pkg::LVL_LOW: scale = n - f20;
            default: scale = n;
        endcase
    endfunction

    // ************************************************************
    // bypass decode
    // ************************************************************
    wire logic [1:0] of_lvl = ofs_sync;
    wire logic of_high = (of_lvl == secondary_coax_output_cfg_pkg::LVL_HIGH);
    wire logic of_res = (of_lvl == secondary_coax_output_cfg_pkg::LVL_RES);
    wire logic of_low = (of_lvl == secondary_coax_output_cfg_pkg::LVL_LOW);
    // receive: high/resistor bypass cable eq, resistor/low reclocker
    wire logic strap_eq_byp = of_high | of_res;
    wire logic strap_rc_byp = of_res | of_low;
    wire logic eq_byp = bypass_override ? bypass_cable_eq_value
                                        : strap_eq_byp;
    wire logic rc_byp = bypass_override ? bypass_reclocker_value
                                        : strap_rc_byp;
    wire logic [1:0] hl_lvl = pick(host_link_override, host_link_value,
                                   hls_sync);

    // ************************************************************
    // coax amplitude, pre-emphasis, edge rate
    // ************************************************************
    localparam logic [SWING_W:0] NOM_DEF =
        (SWING_W+1)'(secondary_coax_output_cfg_pkg::COAX_NOMINAL_MV);
    wire logic [SWING_W:0] nominal = coax_nominal_override
        ? {1'b0, coax_nominal_value} : NOM_DEF;
    wire logic [1:0] amp_lvl = pick(coax_amp_override, coax_amp_value,
                                    amp_sync);
    wire logic [SWING_W:0] next_coax_swing =
        scale(nominal, amp_lvl);

    wire logic uhd_rate = rate_valid &&
        (detected_rate == secondary_coax_output_cfg_pkg::RATE_12G ||
         detected_rate == secondary_coax_output_cfg_pkg::RATE_6G);
    wire logic auto_pre = dir_sync & ~rc_byp & uhd_rate
                          & ~preemph_auto_disable;
    wire logic next_bidir_pre = auto_pre | bidir_preemph_manual;
    wire logic next_sec_pre = secondary_preemph_manual;

    wire logic rate_known = rate_valid &&
        detected_rate <= secondary_coax_output_cfg_pkg::RATE_SD;
    wire logic [2:0] auto_edge = rate_known ? detected_rate
                               : secondary_coax_output_cfg_pkg::EDGE_SLOWEST;
    // no rate is recovered in bypass, so software owns the edge code
    wire logic [2:0] next_edge = rc_byp ? edge_rate_value
                                        : auto_edge;

    // ************************************************************
    // host output swing and de-emphasis
    // ************************************************************
    logic [9:0] tbl_mv;
    logic [5:0] tbl_dem;
    always_comb begin
        unique case (hl_lvl)
            secondary_coax_output_cfg_pkg::LVL_HIGH: begin
                tbl_mv = secondary_coax_output_cfg_pkg::HOST_MV_HIGH;
                tbl_dem = secondary_coax_output_cfg_pkg::HOST_DEM_HIGH;
            end
            secondary_coax_output_cfg_pkg::LVL_FLOAT: begin
                tbl_mv = secondary_coax_output_cfg_pkg::HOST_MV_FLOAT;
                tbl_dem = secondary_coax_output_cfg_pkg::HOST_DEM_FLOAT;
            end
            secondary_coax_output_cfg_pkg::LVL_RES: begin
                tbl_mv = secondary_coax_output_cfg_pkg::HOST_MV_RES;
                tbl_dem = secondary_coax_output_cfg_pkg::HOST_DEM_RES;
            end
            default: begin
                tbl_mv = secondary_coax_output_cfg_pkg::HOST_MV_LOW;
                tbl_dem = secondary_coax_output_cfg_pkg::HOST_DEM_LOW;
            end
        endcase
    end
    wire logic [9:0] mode_mv = dir_sync ? secondary_coax_output_cfg_pkg::HOST_MV_FLOAT
                                        : tbl_mv;
    wire logic [5:0] mode_dem = dir_sync ? secondary_coax_output_cfg_pkg::HOST_DEM_FLOAT
                                         : tbl_dem;
    // each field has its own override so they program independently
    wire logic [9:0] next_host_mv = host_swing_override ? host_swing_value
                                                        : mode_mv;
    wire logic [5:0] next_host_dem = host_deemph_override
        ? host_deemph_value : mode_dem;

    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_mode <= 1'b0;
            cable_eq_enable <= 1'b1;
            host_link_strap_level_enable <= 1'b0;
            reclocker_bypass <= 1'b0;
            fixed_boost_mode <= 1'b0;
            host_link_strap_level <= secondary_coax_output_cfg_pkg::LVL_FLOAT;
            bidir_drive_enable <= 1'b0;
            secondary_drive_enable <= 1'b1;
            coax_swing_mv <= NOM_DEF;
            bidir_preemph_enable <= 1'b0;
            secondary_preemph_enable <= 1'b0;
            preemph_amount <= '0;
            coax_edge_rate <= secondary_coax_output_cfg_pkg::EDGE_SLOWEST;
            bidir_invert <= 1'b0;
            secondary_invert <= 1'b0;
            host_invert <= 1'b0;
            host_loopback_select <= 1'b0;
            host_output_enable <= 1'b1;
            host_swing_mv <= secondary_coax_output_cfg_pkg::HOST_MV_FLOAT;
            host_deemph_tenth_db <= secondary_coax_output_cfg_pkg::HOST_DEM_FLOAT;
        end else begin
            drive_mode <= dir_sync;
            cable_eq_enable <= ~dir_sync & ~eq_byp;
            host_link_strap_level_enable <= dir_sync;
            reclocker_bypass <= rc_byp;
            fixed_boost_mode <= dir_sync & rc_byp;
            host_link_strap_level <= hl_lvl;
            bidir_drive_enable <= dir_sync;
            secondary_drive_enable <= 1'b1;
            coax_swing_mv <= next_coax_swing;
            bidir_preemph_enable <= next_bidir_pre;
            secondary_preemph_enable <= next_sec_pre;
            preemph_amount <= preemph_amount_value;
            coax_edge_rate <= next_edge;
            bidir_invert <= invert_bidir;
            secondary_invert <= invert_secondary;
            host_invert <= invert_host;
            host_loopback_select <= dir_sync;
            host_output_enable <= ~dir_sync | oe_sync;
            host_swing_mv <= next_host_mv;
            host_deemph_tenth_db <= next_host_dem;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_rx_host_enable: assert property (
        !dir_sync |=> host_output_enable)
        else $error("host output off in receive mode");
    a_tx_host_enable: assert property (
        dir_sync |=> host_output_enable == $past(oe_sync))
        else $error("host output enable not following pin");
    a_drive_ports: assert property (
        1'b1 |=> bidir_drive_enable == $past(dir_sync)
                 && secondary_drive_enable)
        else $error("coax driver enables wrong");
    a_float_normal: assert property (
        of_lvl == secondary_coax_output_cfg_pkg::LVL_FLOAT && !bypass_override
        |=> !reclocker_bypass && (drive_mode || cable_eq_enable))
        else $error("floating strap not normal operation");
    a_rx_res_bypass: assert property (
        !dir_sync && of_res && !bypass_override
        |=> reclocker_bypass && !cable_eq_enable)
        else $error("resistor strap must bypass both");
    a_override_bypass: assert property (
        bypass_override |=> reclocker_bypass == $past(bypass_reclocker_value))
        else $error("bypass override ignored");
    a_auto_preemph: assert property (
        dir_sync && !rc_byp && rate_valid && !preemph_auto_disable
        && detected_rate == secondary_coax_output_cfg_pkg::RATE_6G
        |=> bidir_preemph_enable)
        else $error("auto pre-emphasis missing at 6G");
    a_rx_no_preemph: assert property (
        !dir_sync && !bidir_preemph_manual |=> !bidir_preemph_enable)
        else $error("pre-emphasis on in receive mode");
    a_sec_preemph: assert property (
        !secondary_preemph_manual |=> !secondary_preemph_enable)
        else $error("secondary pre-emphasis on by default");
    a_edge_fast: assert property (
        !rc_byp && rate_valid && detected_rate == secondary_coax_output_cfg_pkg::RATE_12G
        |=> coax_edge_rate == 3'h0)
        else $error("12G not fastest edge");
    a_edge_manual: assert property (
        rc_byp |=> coax_edge_rate == $past(edge_rate_value))
        else $error("manual edge rate ignored in bypass");
    a_host_drive_def: assert property (
        dir_sync && !host_swing_override && !host_deemph_override
        |=> host_swing_mv == 10'h23A && host_deemph_tenth_db == 6'h04)
        else $error("drive mode host default wrong");
    a_host_rx_low: assert property (
        !dir_sync && hl_lvl == secondary_coax_output_cfg_pkg::LVL_LOW
        && !host_swing_override |=> host_swing_mv == 10'h33E)
        else $error("host swing for low strap wrong");
    a_coax_plus10: assert property (
        !coax_nominal_override && amp_lvl == secondary_coax_output_cfg_pkg::LVL_RES
        |=> coax_swing_mv == NOM_DEF + NOM_DEF / (SWING_W+1)'(10))
        else $error("resistor amplitude not +10 percent");

    c_drive_preemph: cover property (dir_sync ##1 bidir_preemph_enable);
    c_bypass_edge: cover property (rc_byp ##1 reclocker_bypass);
    c_rx_res: cover property (!dir_sync && of_res ##1 !cable_eq_enable);
    c_host_override: cover property (host_swing_override && dir_sync);
endmodule
`default_nettype wire

/* secondary_coax_output_cfg_pkg.sv */
// Behaviour
// - output-function strap picks equalizer/reclocker bypass
// - floating strap: reclocker on; equalizer on in receive mode only
// - receive: high/resistor/low select bypass combinations
// - drive: resistor/low bypass reclocker, fixed boost
// - override bits replace strap bypass choice
// - bidir drives in drive mode; secondary always
// - amplitude strap scales coax swing around nominal
// - registers override amplitude strap and nominal
// - drive mode auto pre-emphasis at 12G, 6G
// - secondary output pre-emphasis off by default
// - pre-emphasis amount and manual enable by register
// - edge rate auto from rate; 12G fastest
// - polarity inversion on all three outputs
// - host output: equalized data or loop-back
// - receive mode host output always enabled
// - receive: host strap sets swing and de-emphasis
// - drive: host output 570 mV, -0.4 dB default
// - registers override host swing, de-emphasis independently
package secondary_coax_output_cfg_pkg;
    // ************************************************************
    // four-level strap codes
    // ************************************************************
    localparam logic [1:0] LVL_HIGH = 2'h0;
    localparam logic [1:0] LVL_FLOAT = 2'h1;
    localparam logic [1:0] LVL_RES = 2'h2;
    localparam logic [1:0] LVL_LOW = 2'h3;

    // ************************************************************
    // detected rates and edge-rate codes (0 = fastest)
    // ************************************************************
    localparam logic [2:0] RATE_12G = 3'h0;
    localparam logic [2:0] RATE_6G = 3'h1;
    localparam logic [2:0] RATE_3G = 3'h2;
    localparam logic [2:0] RATE_1G5 = 3'h3;
    localparam logic [2:0] RATE_SD = 3'h4;
    localparam logic [2:0] EDGE_SLOWEST = 3'h4;

    // ************************************************************
    // swings in mV, de-emphasis magnitude in tenths of dB
    // ************************************************************
    localparam int COAX_NOMINAL_MV = 800;
    localparam logic [9:0] HOST_MV_HIGH = 10'h190;
    localparam logic [9:0] HOST_MV_FLOAT = 10'h23A;
    localparam logic [9:0] HOST_MV_RES = 10'h294;
    localparam logic [9:0] HOST_MV_LOW = 10'h33E;
    localparam logic [5:0] HOST_DEM_HIGH = 6'h00;
    localparam logic [5:0] HOST_DEM_FLOAT = 6'h04;
    localparam logic [5:0] HOST_DEM_RES = 6'h15;
    localparam logic [5:0] HOST_DEM_LOW = 6'h2C;
endpackage

/* reclocker_rate_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// reclocker rate report seen by the block
// ************************************************************
module reclocker_rate_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] line_rate,
    input wire logic signal_present,
    input wire logic reclocker_bypass,
    output logic [2:0] detected_rate,
    output logic rate_valid
);
    // a bypassed reclocker never locks, so it reports no rate
    wire logic locked = signal_present & ~reclocker_bypass;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rate_valid <= 1'b0;
            detected_rate <= 3'h7;
        end else begin
            rate_valid <= locked;
            // unlocked: keep the code moving so a stale rate is never trusted
            detected_rate <= locked ? line_rate : ~detected_rate;
        end
    end
endmodule
`default_nettype wire

/* sdi_output_path_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin \
    fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); \
    end end
module sdi_output_path_config_tb_top;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic core_clk = 1'b0, rst = 1'b1, direction_mode_select = 1'b0;
    logic [1:0] out_function_strap = 2'h1, coax_amplitude_select = 2'h1;
    logic [1:0] host_link_strap = 2'h1, coax_amp_value = 2'h0;
    logic [1:0] host_link_value = 2'h0;
    logic host_output_enable_pin = 1'b0, bypass_override = 1'b0;
    logic bypass_cable_eq_value = 1'b0, bypass_reclocker_value = 1'b0;
    logic coax_amp_override = 1'b0, coax_nominal_override = 1'b0;
    logic [9:0] coax_nominal_value = 10'h0, host_swing_value = 10'h0;
    logic preemph_auto_disable = 1'b0, bidir_preemph_manual = 1'b0;
    logic secondary_preemph_manual = 1'b0, host_link_override = 1'b0;
    logic [3:0] preemph_amount_value = 4'h0;
    logic [2:0] edge_rate_value = 3'h0, line_rate = 3'h0;
    logic invert_bidir = 1'b0, invert_secondary = 1'b0, invert_host = 1'b0;
    logic host_swing_override = 1'b0, host_deemph_override = 1'b0;
    logic [5:0] host_deemph_value = 6'h0;
    logic signal_present = 1'b0, rate_valid;
    logic [2:0] detected_rate, coax_edge_rate;
    logic drive_mode, cable_eq_enable, host_link_strap_level_enable, reclocker_bypass;
    logic fixed_boost_mode, bidir_drive_enable, secondary_drive_enable;
    logic bidir_preemph_enable, secondary_preemph_enable, bidir_invert;
    logic secondary_invert, host_invert, host_loopback_select;
    logic host_output_enable;
    logic [1:0] host_link_strap_level;
    logic [10:0] coax_swing_mv;
    logic [3:0] preemph_amount;
    logic [9:0] host_swing_mv;
    logic [5:0] host_deemph_tenth_db;
    wire logic [15:0] host_out = {host_swing_mv, host_deemph_tenth_db};
    int fails = 0, compares = 0, cycles = 0;
    // tables indexed by strap code: high, float, resistor, low
    logic [15:0] host_tab [4] = '{16'h6400, 16'h8e84, 16'ha515, 16'hcfac};
    // swing rows: strap levels at 800, then override levels at 1000
    logic [10:0] swing_tab [8] = '{11'h348, 11'h320, 11'h370, 11'h2f8,
        11'h41a, 11'h3e8, 11'h44c, 11'h3b6};

    sdi_output_path_config i_dut (.core_clk, .rst, .direction_mode_select,
        .out_function_strap, .coax_amplitude_select, .host_link_strap,
        .host_output_enable_pin, .detected_rate, .rate_valid,
        .bypass_override, .bypass_cable_eq_value, .bypass_reclocker_value,
        .coax_amp_override, .coax_amp_value, .coax_nominal_override,
        .coax_nominal_value, .preemph_auto_disable, .bidir_preemph_manual,
        .secondary_preemph_manual, .preemph_amount_value, .edge_rate_value,
        .invert_bidir, .invert_secondary, .invert_host, .host_link_override,
        .host_link_value, .host_swing_override, .host_swing_value,
        .host_deemph_override, .host_deemph_value, .drive_mode,
        .cable_eq_enable, .host_link_strap_level_enable, .reclocker_bypass,
        .fixed_boost_mode, .host_link_strap_level, .bidir_drive_enable,
        .secondary_drive_enable, .coax_swing_mv, .bidir_preemph_enable,
        .secondary_preemph_enable, .preemph_amount, .coax_edge_rate,
        .bidir_invert, .secondary_invert, .host_invert,
        .host_loopback_select, .host_output_enable, .host_swing_mv,
        .host_deemph_tenth_db);
    reclocker_rate_model i_rate (.core_clk, .rst, .line_rate,
        .signal_present, .reclocker_bypass, .detected_rate, .rate_valid);

    always #4 core_clk = ~core_clk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic end_of_test;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // pins need 3 edges, rate feedback 2 more; outputs then stand
    task automatic settle;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_defaults;
        `CHK(cable_eq_enable, 1'b1)
        `CHK(reclocker_bypass, 1'b0)
        `CHK(host_output_enable, 1'b1)
        `CHK(bidir_drive_enable, 1'b0)
        `CHK(coax_edge_rate, 3'h4)
    endtask
    task automatic t_decode(input logic drv);
        logic [1:0] l;
        logic [3:0] eq_on_tab = 4'ha;
        logic [3:0] rc_byp_tab = 4'hc;
        for (int i = 0; i < 4; i++) begin
            l = 2'(i);
            @(posedge core_clk);
            direction_mode_select <= drv;
            host_output_enable_pin <= 1'b0;
            out_function_strap <= l;
            host_link_strap <= l;
            settle();
            `CHK(drive_mode, drv)
            `CHK(cable_eq_enable, !drv & eq_on_tab[l])
            `CHK(reclocker_bypass, rc_byp_tab[l])
            `CHK(fixed_boost_mode, drv & rc_byp_tab[l])
            `CHK(host_link_strap_level_enable, drv)
            `CHK(bidir_drive_enable, drv)
            `CHK(secondary_drive_enable, 1'b1)
            `CHK(host_loopback_select, drv)
            `CHK(host_output_enable, !drv)
            `CHK(host_link_strap_level, l)
            `CHK(host_out, host_tab[drv ? 1 : l])
        end
        @(posedge core_clk);
        host_output_enable_pin <= 1'b1;
        out_function_strap <= 2'h1;
        settle();
        `CHK(host_output_enable, 1'b1)
    endtask
    task automatic t_amplitude;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            coax_amplitude_select <= (i < 4) ? 2'(i) : 2'h3;
            coax_amp_override <= i >= 4;
            coax_amp_value <= 2'(i);
            coax_nominal_override <= i >= 4;
            coax_nominal_value <= 10'h3e8;
            settle();
            `CHK(coax_swing_mv, swing_tab[i])
        end
        @(posedge core_clk);
        coax_amp_override <= 1'b0;
        coax_nominal_override <= 1'b0;
    endtask
    task automatic t_rates;
        @(posedge core_clk);
        direction_mode_select <= 1'b1;
        signal_present <= 1'b1;
        preemph_amount_value <= 4'ha;
        for (int r = 0; r < 5; r++) begin
            @(posedge core_clk);
            line_rate <= 3'(r);
            settle();
            `CHK(coax_edge_rate, 3'(r))
            `CHK(bidir_preemph_enable, r < 2)
            `CHK(secondary_preemph_enable, 1'b0)
            `CHK(preemph_amount, 4'ha)
        end
        @(posedge core_clk);
        line_rate <= 3'h0;
        preemph_auto_disable <= 1'b1;
        settle();
        `CHK(bidir_preemph_enable, 1'b0)
        @(posedge core_clk);
        bidir_preemph_manual <= 1'b1;
        secondary_preemph_manual <= 1'b1;
        settle();
        `CHK({bidir_preemph_enable, secondary_preemph_enable}, 2'h3)
        @(posedge core_clk);
        {bidir_preemph_manual, secondary_preemph_manual} <= 2'h0;
        preemph_auto_disable <= 1'b0;
        bypass_override <= 1'b1;
        bypass_reclocker_value <= 1'b1;
        edge_rate_value <= 3'h2;
        settle();
        `CHK(reclocker_bypass, 1'b1)
        `CHK(coax_edge_rate, 3'h2)
        `CHK(bidir_preemph_enable, 1'b0)
        @(posedge core_clk);
        direction_mode_select <= 1'b0;
        bypass_reclocker_value <= 1'b0;
        bypass_cable_eq_value <= 1'b1;
        settle();
        `CHK(cable_eq_enable, 1'b0)
        `CHK(bidir_preemph_enable, 1'b0)
        @(posedge core_clk);
        bypass_override <= 1'b0;
    endtask
    task automatic t_overrides;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            {invert_bidir, invert_secondary, invert_host} <= 3'h1 << i;
            settle();
            `CHK({bidir_invert, secondary_invert, host_invert}, 3'h1 << i)
        end
        @(posedge core_clk);
        host_link_strap <= 2'h3;
        host_swing_override <= 1'b1;
        host_swing_value <= 10'h2bc;
        host_deemph_value <= 6'h0a;
        settle();
        `CHK(host_out, {10'h2bc, 6'h2c})
        @(posedge core_clk);
        {host_swing_override, host_deemph_override} <= 2'h1;
        settle();
        `CHK(host_out, {10'h33e, 6'h0a})
        @(posedge core_clk);
        {host_deemph_override, host_link_override} <= 2'h1;
        settle();
        `CHK({host_swing_mv, host_deemph_tenth_db}, host_tab[0])
        `CHK(host_link_strap_level, 2'h0)
        @(posedge core_clk);
        {direction_mode_select, host_swing_override} <= 2'h3;
        settle();
        `CHK(host_out, {10'h2bc, 6'h04})
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        t_defaults();
        t_decode(1'b0);
        t_decode(1'b1);
        t_amplitude();
        t_rates();
        t_overrides();
        end_of_test();
    end
endmodule
`default_nettype wire
